// >>> common/cdsu_defs.svh
`ifndef CDSU_DEFS_SVH
`define CDSU_DEFS_SVH
`define CDSU_OFF_STATUS    8'h10
`define CDSU_OFF_PC        8'h11
`define CDSU_OFF_SP        8'h12
`define CDSU_OFF_FTHREAD   8'h13
`define CDSU_OFF_FREG      8'h14
`define CDSU_OFF_CAUSE     8'h15
`define CDSU_OFF_DATA      8'h16
`define CDSU_OFF_HALT      8'h18
`define CDSU_OFF_SCRATCH   8'h20
`define CDSU_OFF_IBADDR    8'h30
`define CDSU_OFF_IBCTL     8'h40
`define CDSU_STATUS_WMASK  32'h0000_06DF
`define CDSU_STATUS_MODE   8
`define CDSU_CTL_ENABLE    0
`define CDSU_CTL_COND      1
`define CDSU_CTL_TMASK_LO  16
`define CDSU_CAUSE_LO      0
`define CDSU_UNIT_LO       16
`define CDSU_THREAD_LO     8
`define CDSU_CAUSE_RESET   3'h0
`endif

// >>> common/cdsu_pkg.sv
package cdsu_pkg;
  typedef enum logic [2:0] {
    CDSU_CAUSE_NONE     = 3'h0,
    CDSU_CAUSE_HOST     = 3'h1,
    CDSU_CAUSE_CALL     = 3'h2,
    CDSU_CAUSE_IBREAK   = 3'h3,
    CDSU_CAUSE_DATA     = 3'h4,
    CDSU_CAUSE_RESOURCE = 3'h5
  } cdsu_cause_t;
  typedef enum logic [0:0] {
    CDSU_RUN   = 1'b0,
    CDSU_DEBUG = 1'b1
  } cdsu_mode_t;
endpackage

// >>> design/cdsu_ibreak.sv
`timescale 1ns/1ps
`include "cdsu_defs.svh"
module cdsu_ibreak #(
  parameter int THREADS = 8
) (
  input  wire logic                       i_clock,
  input  wire logic                       i_sys_rst,
  input  wire logic                       i_addr_we,
  input  wire logic                       i_ctl_we,
  input  wire logic [31:0]                i_wdata,
  input  wire logic                       i_pc_valid,
  input  wire logic [31:0]                i_pc,
  input  wire logic [$clog2(THREADS)-1:0] i_thread,
  output logic [31:0]                     o_addr,
  output logic [31:0]                     o_ctl,
  output logic                            o_hit
);
  logic [31:0]        addr_reg;
  logic [31:0]        addr_next;
  logic               en_reg;
  logic               en_next;
  logic               cond_reg;
  logic               cond_next;
  logic [THREADS-1:0] tmask_reg;
  logic [THREADS-1:0] tmask_next;

  always_comb begin
    addr_next  = addr_reg;
    en_next    = en_reg;
    cond_next  = cond_reg;
    tmask_next = tmask_reg;
    if (i_addr_we) begin
      addr_next = i_wdata;
    end
    if (i_ctl_we) begin
      en_next    = i_wdata[`CDSU_CTL_ENABLE];
      cond_next  = i_wdata[`CDSU_CTL_COND];
      tmask_next = i_wdata[`CDSU_CTL_TMASK_LO +: THREADS];
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      addr_reg  <= 32'h0000_0000;
      en_reg    <= 1'b0;
      cond_reg  <= 1'b0;
      tmask_reg <= '0;
    end else begin
      addr_reg  <= addr_next;
      en_reg    <= en_next;
      cond_reg  <= cond_next;
      tmask_reg <= tmask_next;
    end
  end

  // Inequality mode fires on every instruction of a thread in the mask whose pc differs from the address: used for stepping
  assign o_hit = i_pc_valid && en_reg && tmask_reg[i_thread] &&
                 ((i_pc == addr_reg) != cond_reg);
  assign o_addr = addr_reg;
  always_comb begin
    o_ctl = 32'h0000_0000;
    o_ctl[`CDSU_CTL_ENABLE] = en_reg;
    o_ctl[`CDSU_CTL_COND]   = cond_reg;
    o_ctl[`CDSU_CTL_TMASK_LO +: THREADS] = tmask_reg;
  end
endmodule

// >>> design/cdsu_debug_state_unit.sv
`timescale 1ns/1ps
`include "cdsu_defs.svh"
module cdsu_debug_state_unit
  import cdsu_pkg::*;
#(
  parameter int THREADS = 8,
  parameter int UNITS   = 4,
  parameter int SCRATCH = 8
) (
  input  wire logic         i_clock,
  input  wire logic         i_sys_rst,
  // Processor-status access port
  input  wire logic         i_ps_wr,
  input  wire logic         i_ps_rd,
  input  wire logic [7:0]   i_ps_addr,
  input  wire logic [31:0]  i_ps_wdata,
  output logic [31:0]       o_ps_rdata,
  output logic              o_ps_ack,
  // Tile configuration access to shared scratch
  input  wire logic         i_cfg_wr,
  input  wire logic [2:0]   i_cfg_idx,
  input  wire logic [31:0]  i_cfg_wdata,
  output logic [31:0]       o_cfg_rdata,
  // Executing instruction stream
  input  wire logic         i_pc_valid,
  input  wire logic [31:0]  i_pc,
  input  wire logic [2:0]   i_pc_thread,
  // Other debug interrupt sources
  input  wire logic         i_host_req,
  input  wire logic         i_call_req,
  input  wire logic         i_data_req,
  input  wire logic [1:0]   i_data_unit,
  input  wire logic [31:0]  i_data_addr,
  input  wire logic         i_res_req,
  input  wire logic [1:0]   i_res_unit,
  input  wire logic [31:0]  i_res_id,
  input  wire logic [2:0]   i_event_thread,
  // Saved state of the interrupted thread
  input  wire logic [31:0]  i_thread_status,
  input  wire logic [31:0]  i_thread_pc,
  input  wire logic [31:0]  i_thread_sp,
  input  wire logic         i_issue_mode,
  input  wire logic         i_debug_return,
  // Remote register fetch
  output logic [7:0]        o_fetch_thread,
  output logic [4:0]        o_fetch_reg,
  input  wire logic [31:0]  i_fetch_value,
  // Results
  output logic              o_debug_take,
  output logic              o_debug_mode,
  output logic [7:0]        o_thread_halt
);
  // Refused at elaboration: decode and field packing assume these sizes
  if (THREADS != 8 || UNITS != 4 || SCRATCH != 8) begin : g_bad_params
    $error("cdsu: only 8 threads, 4 units and 8 scratch words supported");
  end

  ////////////////////////////////////////////////////////////////////////
  logic [31:0]       status_reg;
  logic [31:0]       status_next;
  logic [31:0]       pc_reg;
  logic [31:0]       pc_next;
  logic [31:0]       sp_reg;
  logic [31:0]       sp_next;
  logic [7:0]        fthread_reg;
  logic [7:0]        fthread_next;
  logic [4:0]        freg_reg;
  logic [4:0]        freg_next;
  logic [2:0]        cause_reg;
  logic [2:0]        cause_next;
  logic [1:0]        unit_reg;
  logic [1:0]        unit_next;
  logic [7:0]        thread_reg;
  logic [7:0]        thread_next;
  logic [31:0]       data_reg;
  logic [31:0]       data_next;
  logic [7:0]        halt_reg;
  logic [7:0]        halt_next;
  logic [31:0]       scratch_reg [SCRATCH];
  logic [31:0]       scratch_next [SCRATCH];
  cdsu_mode_t        mode_reg;
  cdsu_mode_t        mode_next;
  logic [31:0]       rdata_reg;
  logic [31:0]       rdata_next;
  logic              ack_reg;
  logic [UNITS-1:0]  ib_hit;
  logic [31:0]       ib_addr [UNITS];
  logic [31:0]       ib_ctl [UNITS];
  logic [UNITS-1:0]  ib_addr_we;
  logic [UNITS-1:0]  ib_ctl_we;
  logic              take;
  cdsu_cause_t       take_cause;
  logic [1:0]        take_unit;
  logic [7:0]        take_thread;
  logic [31:0]       take_data;

  ////////////////////////////////////////////////////////////////////////
  // Breakpoint comparators
  genvar gu;
  generate
    for (gu = 0; gu < UNITS; gu++) begin : g_ib
      assign ib_addr_we[gu] = i_ps_wr &&
        (i_ps_addr == (`CDSU_OFF_IBADDR + 8'(gu)));
      assign ib_ctl_we[gu] = i_ps_wr &&
        (i_ps_addr == (`CDSU_OFF_IBCTL + 8'(gu)));
      cdsu_ibreak #(
        .THREADS (THREADS)
      ) u_ib (
        .i_clock    (i_clock),
        .i_sys_rst  (i_sys_rst),
        .i_addr_we  (ib_addr_we[gu]),
        .i_ctl_we   (ib_ctl_we[gu]),
        .i_wdata    (i_ps_wdata),
        .i_pc_valid (i_pc_valid && mode_reg == CDSU_RUN),
        .i_pc       (i_pc),
        .i_thread   (i_pc_thread),
        .o_addr     (ib_addr[gu]),
        .o_ctl      (ib_ctl[gu]),
        .o_hit      (ib_hit[gu])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Cause arbitration: host first, then call, ibreak, data, resource
  always_comb begin
    take        = 1'b0;
    take_cause  = CDSU_CAUSE_NONE;
    take_unit   = 2'h0;
    take_thread = {5'h00, i_event_thread};
    take_data   = data_reg;
    if (mode_reg == CDSU_RUN) begin
      if (i_host_req) begin
        take        = 1'b1;
        take_cause  = CDSU_CAUSE_HOST;
        take_thread = 8'h00;
      end else if (i_call_req) begin
        take       = 1'b1;
        take_cause = CDSU_CAUSE_CALL;
      end else if (|ib_hit) begin
        take        = 1'b1;
        take_cause  = CDSU_CAUSE_IBREAK;
        take_thread = {5'h00, i_pc_thread};
        // Lowest numbered comparator wins
        if (ib_hit[0]) begin
          take_unit = 2'h0;
        end else if (ib_hit[1]) begin
          take_unit = 2'h1;
        end else if (ib_hit[2]) begin
          take_unit = 2'h2;
        end else begin
          take_unit = 2'h3;
        end
      end else if (i_data_req) begin
        take       = 1'b1;
        take_cause = CDSU_CAUSE_DATA;
        take_unit  = i_data_unit;
        take_data  = i_data_addr;
      end else if (i_res_req) begin
        take       = 1'b1;
        take_cause = CDSU_CAUSE_RESOURCE;
        take_unit  = i_res_unit;
        take_data  = i_res_id;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file and capture
  always_comb begin
    status_next  = status_reg;
    pc_next      = pc_reg;
    sp_next      = sp_reg;
    fthread_next = fthread_reg;
    freg_next    = freg_reg;
    cause_next   = cause_reg;
    unit_next    = unit_reg;
    thread_next  = thread_reg;
    data_next    = data_reg;
    halt_next    = halt_reg;
    mode_next    = mode_reg;
    for (int i = 0; i < SCRATCH; i++) begin
      scratch_next[i] = scratch_reg[i];
    end
    if (i_cfg_wr) begin
      scratch_next[i_cfg_idx] = i_cfg_wdata;
    end
    if (i_ps_wr) begin
      if (i_ps_addr == `CDSU_OFF_STATUS) begin
        status_next = i_ps_wdata & `CDSU_STATUS_WMASK;
      end else if (i_ps_addr == `CDSU_OFF_PC) begin
        pc_next = i_ps_wdata;
      end else if (i_ps_addr == `CDSU_OFF_SP) begin
        sp_next = i_ps_wdata;
      end else if (i_ps_addr == `CDSU_OFF_FTHREAD) begin
        fthread_next = i_ps_wdata[7:0];
      end else if (i_ps_addr == `CDSU_OFF_FREG) begin
        freg_next = i_ps_wdata[4:0];
      end else if (i_ps_addr == `CDSU_OFF_CAUSE) begin
        cause_next  = i_ps_wdata[`CDSU_CAUSE_LO +: 3];
        unit_next   = i_ps_wdata[`CDSU_UNIT_LO +: 2];
        thread_next = i_ps_wdata[`CDSU_THREAD_LO +: 8];
      end else if (i_ps_addr == `CDSU_OFF_DATA) begin
        data_next = i_ps_wdata;
      end else if (i_ps_addr == `CDSU_OFF_HALT) begin
        halt_next = i_ps_wdata[7:0];
      end else if (i_ps_addr[7:3] == `CDSU_OFF_SCRATCH >> 3) begin
        scratch_next[i_ps_addr[2:0]] = i_ps_wdata;
      end
    end
    if (i_debug_return) begin
      mode_next = CDSU_RUN;
    end
    // Capture wins over a register write in the same cycle
    if (take) begin
      mode_next   = CDSU_DEBUG;
      status_next = i_thread_status & `CDSU_STATUS_WMASK;
      pc_next     = i_thread_pc;
      sp_next     = i_thread_sp;
      cause_next  = take_cause;
      unit_next   = take_unit;
      thread_next = take_thread;
      data_next   = take_data;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      status_reg  <= 32'h0000_0000;
      pc_reg      <= 32'h0000_0000;
      sp_reg      <= 32'h0000_0000;
      fthread_reg <= 8'h00;
      freg_reg    <= 5'h00;
      cause_reg   <= `CDSU_CAUSE_RESET;
      unit_reg    <= 2'h0;
      thread_reg  <= 8'h00;
      data_reg    <= 32'h0000_0000;
      halt_reg    <= 8'h00;
      mode_reg    <= CDSU_RUN;
      for (int i = 0; i < SCRATCH; i++) begin
        scratch_reg[i] <= 32'h0000_0000;
      end
    end else begin
      status_reg  <= status_next;
      pc_reg      <= pc_next;
      sp_reg      <= sp_next;
      fthread_reg <= fthread_next;
      freg_reg    <= freg_next;
      cause_reg   <= cause_next;
      unit_reg    <= unit_next;
      thread_reg  <= thread_next;
      data_reg    <= data_next;
      halt_reg    <= halt_next;
      mode_reg    <= mode_next;
      for (int i = 0; i < SCRATCH; i++) begin
        scratch_reg[i] <= scratch_next[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path, one cycle latency
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (i_ps_addr == `CDSU_OFF_STATUS) begin
      rdata_next = status_reg;
      rdata_next[`CDSU_STATUS_MODE] = i_issue_mode;
    end else if (i_ps_addr == `CDSU_OFF_PC) begin
      rdata_next = pc_reg;
    end else if (i_ps_addr == `CDSU_OFF_SP) begin
      rdata_next = sp_reg;
    end else if (i_ps_addr == `CDSU_OFF_FTHREAD) begin
      rdata_next = {24'h000000, fthread_reg};
    end else if (i_ps_addr == `CDSU_OFF_FREG) begin
      rdata_next = {27'h0000000, freg_reg};
    end else if (i_ps_addr == `CDSU_OFF_CAUSE) begin
      rdata_next = {14'h0000, unit_reg, thread_reg, 5'h00, cause_reg};
    end else if (i_ps_addr == `CDSU_OFF_DATA) begin
      rdata_next = data_reg;
    end else if (i_ps_addr == `CDSU_OFF_HALT) begin
      rdata_next = {24'h000000, halt_reg};
    end else if (i_ps_addr[7:3] == `CDSU_OFF_SCRATCH >> 3) begin
      rdata_next = scratch_reg[i_ps_addr[2:0]];
    end else if (i_ps_addr[7:2] == `CDSU_OFF_IBADDR >> 2) begin
      rdata_next = ib_addr[i_ps_addr[1:0]];
    end else if (i_ps_addr[7:2] == `CDSU_OFF_IBCTL >> 2) begin
      rdata_next = ib_ctl[i_ps_addr[1:0]];
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rdata_reg <= 32'h0000_0000;
      ack_reg   <= 1'b0;
    end else begin
      rdata_reg <= i_ps_rd ? rdata_next : rdata_reg;
      ack_reg   <= i_ps_rd | i_ps_wr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign o_ps_rdata     = rdata_reg;
  assign o_ps_ack       = ack_reg;
  assign o_cfg_rdata    = scratch_reg[i_cfg_idx];
  assign o_fetch_thread = fthread_reg;
  assign o_fetch_reg    = freg_reg;
  assign o_debug_take   = take;
  assign o_debug_mode   = (mode_reg == CDSU_DEBUG);
  // Halting applies only while not in debug mode
  assign o_thread_halt  = (mode_reg == CDSU_RUN) ? halt_reg : 8'h00;

  ////////////////////////////////////////////////////////////////////////
  sequence s_take;
    take;
  endsequence

  AST_CAPTURE_PC: assert property (
    @(posedge i_clock) disable iff (i_sys_rst)
    s_take |=> pc_reg == $past(i_thread_pc))
    else $error("saved pc not captured");
  AST_CAPTURE_SP: assert property (
    @(posedge i_clock) disable iff (i_sys_rst)
    s_take |=> sp_reg == $past(i_thread_sp))
    else $error("saved sp not captured");
  AST_CAPTURE_ST: assert property (
    @(posedge i_clock) disable iff (i_sys_rst)
    s_take |=> status_reg[7:0] == ($past(i_thread_status[7:0]) & 8'hDF))
    else $error("saved status not captured");
  AST_HOST_THREAD: assert property (
    @(posedge i_clock) disable iff (i_sys_rst)
    (take && i_host_req) |=> thread_reg == 8'h00 && cause_reg == 3'h1 &&
    unit_reg == 2'h0)
    else $error("host request fields wrong");
  // Recorded unit must have hit, and no lower-numbered unit may have hit
  AST_IB_LOWEST: assert property (
    @(posedge i_clock) disable iff (i_sys_rst)
    (take && take_cause == CDSU_CAUSE_IBREAK) |=> cause_reg == 3'h3 &&
    ((($past(ib_hit) >> unit_reg) & 4'h1) == 4'h1) &&
    (($past(ib_hit) & ((4'h1 << unit_reg) - 4'h1)) == 4'h0))
    else $error("lowest breakpoint not recorded");
  AST_DATA_ADDR: assert property (
    @(posedge i_clock) disable iff (i_sys_rst)
    (take && take_cause == CDSU_CAUSE_DATA) |=> data_reg == $past(i_data_addr)
    && cause_reg == 3'h4)
    else $error("watch address not captured");
  AST_RES_ID: assert property (
    @(posedge i_clock) disable iff (i_sys_rst)
    (take && take_cause == CDSU_CAUSE_RESOURCE) |=> data_reg == $past(i_res_id)
    && cause_reg == 3'h5)
    else $error("resource id not captured");
  AST_HALT: assert property (
    @(posedge i_clock) disable iff (i_sys_rst)
    !o_debug_mode |-> o_thread_halt == halt_reg)
    else $error("halt mask not applied");
  AST_MODE_BIT: assert property (
    @(posedge i_clock) disable iff (i_sys_rst)
    (i_ps_rd && i_ps_addr == 8'h10) |=> o_ps_rdata[8] == $past(i_issue_mode))
    else $error("issue mode not reflected");
endmodule

// >>> sim/cdsu_thread_model.sv
`timescale 1ns/1ps
module cdsu_thread_model (
  input  wire logic [2:0]  i_thread,
  input  wire logic [7:0]  i_fetch_thread,
  input  wire logic [4:0]  i_fetch_reg,
  output logic      [31:0] o_status,
  output logic      [31:0] o_pc,
  output logic      [31:0] o_sp,
  output logic      [31:0] o_fetch_value
);
  // Per-thread patterns, so capturing the wrong thread shows up
  assign o_status = ~{29'h0, i_thread};
  assign o_pc     = 32'h8000_0000 | {25'h0, i_thread, 4'h0};
  assign o_sp     = 32'h0001_0000 | {29'h0, i_thread};
  // Register file answer for the selected thread and index
  assign o_fetch_value = {i_fetch_thread, 19'h0, i_fetch_reg};
endmodule

// >>> sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        i_clock, i_sys_rst, ps_wr, ps_rd, cfg_wr, pc_valid;
  logic        host, call, data_req, res_req, issue_mode, debug_return;
  logic [7:0]  ps_addr, fetch_thread, thread_halt;
  logic [31:0] ps_wdata, ps_rdata, cfg_wdata, cfg_rdata, pc;
  logic [31:0] data_addr, res_id, status, tpc, tsp, fval;
  logic [2:0]  cfg_idx, cur_thr;
  logic [1:0]  data_unit, res_unit;
  logic [4:0]  fetch_reg;
  logic        ps_ack, debug_take, debug_mode;
  int          fail_count, compares;

  cdsu_debug_state_unit i_cdsu_debug_state_unit (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_ps_wr(ps_wr),
    .i_ps_rd(ps_rd), .i_ps_addr(ps_addr), .i_ps_wdata(ps_wdata),
    .o_ps_rdata(ps_rdata), .o_ps_ack(ps_ack), .i_cfg_wr(cfg_wr),
    .i_cfg_idx(cfg_idx), .i_cfg_wdata(cfg_wdata), .o_cfg_rdata(cfg_rdata),
    .i_pc_valid(pc_valid), .i_pc(pc), .i_pc_thread(cur_thr),
    .i_host_req(host), .i_call_req(call), .i_data_req(data_req),
    .i_data_unit(data_unit), .i_data_addr(data_addr), .i_res_req(res_req),
    .i_res_unit(res_unit), .i_res_id(res_id), .i_event_thread(cur_thr),
    .i_thread_status(status), .i_thread_pc(tpc), .i_thread_sp(tsp),
    .i_issue_mode(issue_mode), .i_debug_return(debug_return),
    .o_fetch_thread(fetch_thread), .o_fetch_reg(fetch_reg),
    .i_fetch_value(fval), .o_debug_take(debug_take),
    .o_debug_mode(debug_mode), .o_thread_halt(thread_halt));

  cdsu_thread_model i_cdsu_thread_model (
    .i_thread(cur_thr), .i_fetch_thread(fetch_thread),
    .i_fetch_reg(fetch_reg), .o_status(status), .o_pc(tpc), .o_sp(tsp),
    .o_fetch_value(fval));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // One strobe cycle; ack and read data land on the following edge
  task automatic ps_access(input logic wr, input logic [7:0] a,
                           input logic [31:0] d);
    @(posedge i_clock);
    ps_wr    <= wr;
    ps_rd    <= !wr;
    ps_addr  <= a;
    ps_wdata <= d;
    @(posedge i_clock);
    ps_wr <= 1'b0;
    ps_rd <= 1'b0;
    #1;
    check("ack", {31'h0, ps_ack}, 32'h1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string name);
    ps_access(1'b0, a, 32'h0);
    check(name, ps_rdata, e);
  endtask

  // Kind 1 host, 2 call, 3 executing pc, 4 data, 5 resource
  task automatic fire(input int kind, input logic [2:0] thr,
                      input logic [1:0] u, input logic [31:0] d,
                      input logic exp);
    @(posedge i_clock);
    cur_thr   <= thr;
    host      <= (kind == 1);
    call      <= (kind == 2);
    pc_valid  <= (kind == 3);
    data_req  <= (kind == 4);
    res_req   <= (kind == 5);
    data_unit <= u;
    res_unit  <= u;
    pc        <= d;
    data_addr <= d;
    res_id    <= d;
    #1;
    check("take", {31'h0, debug_take}, {31'h0, exp});
    @(posedge i_clock);
    host     <= 1'b0;
    call     <= 1'b0;
    pc_valid <= 1'b0;
    data_req <= 1'b0;
    res_req  <= 1'b0;
    #1;
    if (exp) check("mode", {31'h0, debug_mode}, 32'h1);
  endtask

  task automatic leave();
    @(posedge i_clock);
    debug_return <= 1'b1;
    @(posedge i_clock);
    debug_return <= 1'b0;
    #1;
    check("mode", {31'h0, debug_mode}, 32'h0);
  endtask

  task automatic verify(input logic [2:0] cause, input logic [7:0] tf,
                        input logic [1:0] u, input logic [2:0] thr);
    logic [31:0] st;
    st = (~{29'h0, thr} & 32'h0000_06DF) | {23'h0, issue_mode, 8'h00};
    rd(8'h15, {14'h0, u, tf, 5'h00, cause}, "cause");
    rd(8'h10, st, "status");
    rd(8'h11, 32'h8000_0000 | {25'h0, thr, 4'h0}, "pc");
    rd(8'h12, 32'h0001_0000 | {29'h0, thr}, "sp");
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(8'h15, 32'h0, "cause");
    ps_access(1'b1, 8'h17, 32'hFFFF_FFFF);
    rd(8'h17, 32'h0, "unmapped");
  endtask

  task automatic t_scratch();
    for (int i = 0; i < 8; i++) begin
      ps_access(1'b1, 8'h20 + i[7:0], 32'hC0DE_0000 + i);
      cfg_idx <= i[2:0];
      #1;
      check("cfg", cfg_rdata, 32'hC0DE_0000 + i);
    end
    @(posedge i_clock);
    cfg_wr    <= 1'b1;
    cfg_idx   <= 3'h3;
    cfg_wdata <= 32'h1234_ABCD;
    @(posedge i_clock);
    cfg_wr <= 1'b0;
    rd(8'h23, 32'h1234_ABCD, "scratch");
  endtask

  task automatic t_regs();
    ps_access(1'b1, 8'h10, 32'hFFFF_FFFF);
    rd(8'h10, 32'h0000_07DF, "status");
    issue_mode <= 1'b0;
    rd(8'h10, 32'h0000_06DF, "status");
    issue_mode <= 1'b1;
    ps_access(1'b1, 8'h11, 32'hA5A5_5A5A);
    rd(8'h11, 32'hA5A5_5A5A, "pc");
    ps_access(1'b1, 8'h12, 32'h5A5A_A5A5);
    rd(8'h12, 32'h5A5A_A5A5, "sp");
    ps_access(1'b1, 8'h13, 32'hFFFF_FF5A);
    rd(8'h13, 32'h0000_005A, "thread sel");
    check("fetch thread", {24'h0, fetch_thread}, 32'h5A);
    ps_access(1'b1, 8'h14, 32'hFFFF_FFF3);
    rd(8'h14, 32'h0000_0013, "reg sel");
    check("fetch reg", {27'h0, fetch_reg}, 32'h13);
  endtask

  task automatic t_events();
    fire(1, 3'h5, 2'h2, 32'h0, 1'b1);
    verify(3'h1, 8'h00, 2'h0, 3'h5);
    leave();
    fire(4, 3'h6, 2'h2, 32'hDEAD_0040, 1'b1);
    verify(3'h4, 8'h06, 2'h2, 3'h6);
    rd(8'h16, 32'hDEAD_0040, "data");
    leave();
    fire(2, 3'h3, 2'h2, 32'h0, 1'b1);
    verify(3'h2, 8'h03, 2'h0, 3'h3);
    rd(8'h16, 32'hDEAD_0040, "data");
    leave();
    fire(5, 3'h1, 2'h3, 32'h0000_0A17, 1'b1);
    verify(3'h5, 8'h01, 2'h3, 3'h1);
    rd(8'h16, 32'h0000_0A17, "data");
    leave();
  endtask

  task automatic t_ibreak();
    ps_access(1'b1, 8'h32, 32'h0000_0100);
    ps_access(1'b1, 8'h33, 32'h0000_0100);
    ps_access(1'b1, 8'h42, 32'h0010_0001);
    ps_access(1'b1, 8'h43, 32'h0010_0001);
    rd(8'h32, 32'h0000_0100, "bp addr");
    rd(8'h42, 32'h0010_0001, "bp ctl");
    fire(3, 3'h3, 2'h0, 32'h0000_0100, 1'b0);
    fire(3, 3'h4, 2'h0, 32'h0000_0104, 1'b0);
    fire(3, 3'h4, 2'h0, 32'h0000_0100, 1'b1);
    verify(3'h3, 8'h04, 2'h2, 3'h4);
    leave();
    ps_access(1'b1, 8'h31, 32'h0000_0200);
    ps_access(1'b1, 8'h41, 32'h0004_0003);
    fire(3, 3'h2, 2'h0, 32'h0000_0200, 1'b0);
    fire(3, 3'h2, 2'h0, 32'h0000_0204, 1'b1);
    verify(3'h3, 8'h02, 2'h1, 3'h2);
    ps_access(1'b1, 8'h41, 32'h0000_0000);
    leave();
  endtask

  task automatic t_halt();
    ps_access(1'b1, 8'h18, 32'h0000_01A5);
    rd(8'h18, 32'h0000_00A5, "halt reg");
    check("halt", {24'h0, thread_halt}, 32'hA5);
    fire(1, 3'h0, 2'h0, 32'h0, 1'b1);
    check("halt", {24'h0, thread_halt}, 32'h0);
    fire(2, 3'h1, 2'h0, 32'h0, 1'b0);
    rd(8'h15, 32'h0000_0001, "cause");
    leave();
    check("halt", {24'h0, thread_halt}, 32'hA5);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end

  initial begin
    #(50 * 4000);
    fail_count++;
    conclude();
  end

  initial begin
    {ps_wr, ps_rd, cfg_wr, pc_valid, host, call} = 6'h00;
    {data_req, res_req, debug_return} = 3'h0;
    {ps_addr, ps_wdata, cfg_wdata, pc, data_addr, res_id} = 168'h0;
    {cfg_idx, cur_thr, data_unit, res_unit} = 10'h000;
    issue_mode = 1'b1;
    i_sys_rst  = 1'b1;
    repeat (5) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    t_reset();
    t_scratch();
    t_regs();
    t_events();
    t_ibreak();
    t_halt();
    conclude();
  end
endmodule
